/* File: dpram_host_pkg.sv */
// constants and types for the dual-port ram port controller
package dpram_host_pkg;
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned ADDR_W               = 11;
  localparam int unsigned DATA_W               = 8;
  localparam logic [10:0] MBOX_LEFT_ADDR       = 11'h7FF;
  localparam logic [10:0] MBOX_RIGHT_ADDR      = 11'h7FE;
  // timing figures in ns
  localparam int unsigned ACCESS_TIME_NS       = 55;
  localparam int unsigned WRITE_PULSE_NS       = 30;
  localparam int unsigned DATA_SETUP_NS        = 20;
  localparam int unsigned PRIORITY_SETUP_TIME_NS = 5;
  localparam int unsigned WRITE_HOLD_AFTER_RELEASE_NS = 30;
  localparam int unsigned RELEASE_TO_DATA_TIME_NS = 45;
  // cycle counts, least times rounded up
  localparam int unsigned ACCESS_CYC  = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPULSE_CYC  = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC   = (PRIORITY_SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WHOLD_CYC   = (WRITE_HOLD_AFTER_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BDD_CYC     = (RELEASE_TO_DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DSETUP_CYC  = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ACTIVE = 3'b011,
    ST_HOLD   = 3'b010,
    ST_DONE   = 3'b110
  } state_t;
endpackage

/* File: dpram_port_host.sv */
// controller that drives one port of the dual-port static ram
`timescale 1ns/1ps
// What this block does
// - followers widen word using arbiter busy
// - data stable around write-ending rising edge
// - earlier valid port by setup time wins
// - hold strobe low after busy releases
// - strobe stays high during reads
module dpram_port_host
  import dpram_host_pkg::*;
#(
  parameter logic [10:0] OWN_MBOX_ADDR = MBOX_LEFT_ADDR,
  parameter logic [10:0] PEER_MBOX_ADDR = MBOX_RIGHT_ADDR
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [10:0]       req_addr,
  input  wire logic [7:0]        req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_rdata,
  output logic                   mbox_pending,
  output logic [10:0]            ram_addr,
  output logic                   ram_ce_n,
  output logic                   ram_rw_n,
  output logic                   ram_oe_n,
  output logic [7:0]             ram_data_o,
  output logic                   ram_data_oe,
  input  wire logic [7:0]        ram_data_i,
  input  wire logic              ram_busy_n,
  input  wire logic              ram_int_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;
  logic       busy_s1_q;
  logic       busy_s2_q;
  logic       int_s1_q;
  logic       int_s2_q;

  always_ff @(posedge clock) begin
    data_s1_q <= ram_data_i;
    data_s2_q <= data_s1_q;
    busy_s1_q <= ram_busy_n;
    busy_s2_q <= busy_s1_q;
    int_s1_q  <= ram_int_n;
    int_s2_q  <= int_s1_q;
  end

  wire busy = ~busy_s2_q;
  assign mbox_pending = ~int_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // request capture and sequencing
  state_t      state_q;
  state_t      state_d;
  logic [7:0]  cnt_q;
  logic [7:0]  cnt_d;
  logic        wr_q;
  logic [10:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        rsp_q;
  logic        was_busy_q;

  // cycle figure cut to the counter width
  function automatic logic [7:0] cyc8(input int unsigned n);
    cyc8 = n[7:0];
  endfunction

  assign req_ready = (state_q == ST_IDLE);
  wire take     = req_valid & req_ready;
  wire cnt_zero = (cnt_q == CNT_ZERO);

  // read wait: access time, or release-to-data after busy
  wire [7:0] read_wait  = was_busy_q ? cyc8(BDD_CYC) : cyc8(ACCESS_CYC);
  // write wait: pulse width, or hold after busy release
  wire [7:0] write_wait = was_busy_q ? cyc8(WHOLD_CYC) : cyc8(WPULSE_CYC);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_SETUP;
          cnt_d   = cyc8(SETUP_CYC);
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          state_d = ST_ACTIVE;
          cnt_d   = wr_q ? cyc8(WPULSE_CYC) : cyc8(ACCESS_CYC);
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_ACTIVE: begin
        if (busy) begin
          // contested: hold the access until granted
          cnt_d = wr_q ? write_wait : read_wait;
          if (!was_busy_q) begin
            cnt_d = wr_q ? cyc8(WHOLD_CYC) : cyc8(BDD_CYC);
          end
        end else if (cnt_zero) begin
          state_d = ST_HOLD;
          cnt_d   = CNT_ZERO;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_HOLD: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q       <= 1'b0;
      addr_q     <= 11'h000;
      wdata_q    <= 8'h00;
      was_busy_q <= 1'b0;
    end else begin
      if (take) begin
        wr_q       <= req_write;
        addr_q     <= req_addr;
        wdata_q    <= req_wdata;
        was_busy_q <= 1'b0;
      end else if (state_q == ST_ACTIVE && busy) begin
        was_busy_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  wire in_cycle    = (state_q == ST_SETUP) | (state_q == ST_ACTIVE) | (state_q == ST_HOLD);
  wire drive_next  = (state_d == ST_ACTIVE) | (state_d == ST_HOLD);
  // strobe falls after select, rises one cycle before data is released
  wire strobe_next = wr_q & (state_d == ST_ACTIVE) & (state_q != ST_IDLE);
  wire read_next   = ~wr_q & drive_next & (state_q != ST_IDLE);

  always_ff @(posedge clock) begin
    if (rst) begin
      ram_addr    <= 11'h000;
      ram_ce_n    <= 1'b1;
      ram_rw_n    <= 1'b1;
      ram_oe_n    <= 1'b1;
      ram_data_o  <= 8'h00;
      ram_data_oe <= 1'b0;
    end else begin
      ram_addr    <= take ? req_addr : addr_q;
      ram_ce_n    <= ~(in_cycle | take);
      ram_rw_n    <= ~strobe_next;
      ram_oe_n    <= ~(read_next);
      ram_data_o  <= wdata_q;
      ram_data_oe <= wr_q & drive_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture and answer
  wire capture = (state_q == ST_HOLD) & ~wr_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= (state_q == ST_DONE);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (capture) begin
      rdata_q <= data_s2_q;
    end
  end

  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;

endmodule

/* File: dpram_dev_model.sv */
// behavioural model of the dual-port ram seen from the left port
`timescale 1ns/1ps
module dpram_dev_model
  import dpram_host_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [10:0] addr,
  input  wire logic        ce_n,
  input  wire logic        rw_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  wdata,
  input  wire logic        busy_req,
  input  wire logic        peer_set,
  output logic [7:0]       rdata,
  output logic             busy_n,
  output logic             int_n
);
  logic [7:0]  mem [0:2047];
  logic        wr_q = 1'b0;
  logic [10:0] a_q;
  logic [7:0]  d_q;
  logic [7:0]  last_q = 8'h00;
  logic        int_q = 1'b0;
  wire         wr_on = !ce_n && !rw_n;
  wire         rd_on = !ce_n && !oe_n && rw_n;
  assign busy_n = !(busy_req && !ce_n);
  assign int_n  = !int_q;
  assign rdata  = !rd_on ? ~last_q : (busy_req ? last_q : mem[addr]);
  always @(posedge clock) begin
    if (wr_q && !wr_on && !busy_req) begin
      mem[a_q] <= d_q;
    end
    if (peer_set) begin
      int_q <= 1'b1;
    end else if (rd_on && addr == MBOX_RIGHT_ADDR) begin
      int_q <= 1'b0;
    end
    if (rd_on && !busy_req) begin
      last_q <= mem[addr];
    end
    wr_q <= wr_on;
    a_q <= addr;
    d_q <= wdata;
  end
endmodule

/* File: dpram_host_props.sv */
// assertions on the pin side of the port controller
`timescale 1ns/1ps
module dpram_host_props
  import dpram_host_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [10:0] ram_addr,
  input wire logic        ram_ce_n,
  input wire logic        ram_rw_n,
  input wire logic        ram_oe_n,
  input wire logic [7:0]  ram_data_o,
  input wire logic        ram_data_oe,
  input wire logic        ram_busy_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_rd_strobe_high: assert property (!ram_oe_n |-> ram_rw_n)
    else $error("strobe low in read");
  a_wr_data_hold: assert property ($rose(ram_rw_n) |-> ram_data_oe && $stable(ram_data_o))
    else $error("data moved at write end");
  a_wr_data_setup: assert property ($rose(ram_rw_n) |-> $past(ram_data_oe, 2))
    else $error("data setup short");
  a_busy_wr_hold: assert property ($rose(ram_busy_n) && !ram_rw_n |=> !ram_rw_n [*3])
    else $error("strobe ended early");
  a_addr_steady: assert property (!ram_ce_n && !$past(ram_ce_n) |-> $stable(ram_addr))
    else $error("address moved");
  c_write: cover property ($rose(ram_rw_n));
  c_read: cover property (!ram_oe_n);
  c_busy: cover property ($rose(ram_busy_n) && !ram_ce_n);
endmodule

/* File: dpram_port_host_tb_top.sv */
// self-checking bench for the dual-port ram port controller
`timescale 1ns/1ps
module dpram_port_host_tb_top
  import dpram_host_pkg::*;
;
  logic        clock = 0, rst = 1, req_valid = 0, req_write = 0, busy_req = 0, peer_set = 0;
  logic [10:0] req_addr = 11'h000;
  logic [7:0]  req_wdata = 8'h00, got;
  wire         req_ready, rsp_valid, mbox_pending, ram_ce_n, ram_rw_n, ram_oe_n, ram_data_oe, busy_n, int_n;
  wire  [7:0]  rsp_rdata, ram_data_o, dev_rdata, data_bus;
  wire  [10:0] ram_addr;
  int          err_total = 0, n_checks = 0;
  assign data_bus = ram_data_oe ? ram_data_o : dev_rdata;
  always #5 clock = ~clock;
  dpram_port_host dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .mbox_pending(mbox_pending), .ram_addr(ram_addr), .ram_ce_n(ram_ce_n),
    .ram_rw_n(ram_rw_n), .ram_oe_n(ram_oe_n), .ram_data_o(ram_data_o), .ram_data_oe(ram_data_oe),
    .ram_data_i(data_bus), .ram_busy_n(busy_n), .ram_int_n(int_n));
  dpram_dev_model u_dev (.clock(clock), .addr(ram_addr), .ce_n(ram_ce_n), .rw_n(ram_rw_n),
    .oe_n(ram_oe_n), .wdata(data_bus), .busy_req(busy_req), .peer_set(peer_set),
    .rdata(dev_rdata), .busy_n(busy_n), .int_n(int_n));
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic do_req(input logic w, input logic [10:0] a, input logic [7:0] d, input int bsy);
    int n;
    logic [7:0] old;
    old = u_dev.mem[a];
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) begin
      err_total++;
      final_report();
    end
    req_valid <= 1'b0;
    if (bsy > 0) begin
      repeat (bsy) @(posedge clock);
      chk("held byte", u_dev.mem[a], old);
      busy_req <= 1'b0;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && n < 300);
    if (rsp_valid !== 1'b1) begin
      err_total++;
      final_report();
    end else begin
      got = rsp_rdata;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_rw();
    do_req(1'b1, 11'h000, 8'hA5, 0);
    do_req(1'b1, 11'h7FD, 8'h3C, 0);
    do_req(1'b0, 11'h000, 8'h00, 0);
    chk("low byte", got, 8'hA5);
    do_req(1'b0, 11'h7FD, 8'h00, 0);
    chk("high byte", got, 8'h3C);
  endtask
  task automatic s_busy();
    do_req(1'b1, 11'h040, 8'h00, 0);
    busy_req <= 1'b1;
    do_req(1'b1, 11'h040, 8'hC3, 12);
    do_req(1'b0, 11'h040, 8'h00, 0);
    chk("busy write", got, 8'hC3);
    busy_req <= 1'b1;
    do_req(1'b0, 11'h7FD, 8'h00, 8);
    chk("busy read", got, 8'h3C);
  endtask
  task automatic s_mbox();
    peer_set <= 1'b1;
    @(posedge clock);
    peer_set <= 1'b0;
    repeat (4) @(posedge clock);
    chk("pending set", 8'(mbox_pending), 8'h01);
    do_req(1'b0, MBOX_RIGHT_ADDR, 8'h00, 0);
    repeat (4) @(posedge clock);
    chk("pending clear", 8'(mbox_pending), 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("idle pins", {4'h0, ram_ce_n, ram_rw_n, ram_oe_n, ram_data_oe}, 8'h0E);
    s_rw();
    s_busy();
    s_mbox();
    final_report();
  end
endmodule
bind dpram_port_host dpram_host_props u_props (.clock(clock), .rst(rst), .ram_addr(ram_addr),
  .ram_ce_n(ram_ce_n), .ram_rw_n(ram_rw_n), .ram_oe_n(ram_oe_n), .ram_data_o(ram_data_o),
  .ram_data_oe(ram_data_oe), .ram_busy_n(ram_busy_n));
